// ==== rtl/csc_setup_control.sv ====
// per-channel setup registers and running average for the converter
// assumes all inputs come from logic on sys_clk; no synchronisers needed
`timescale 1ns/10ps
module csc_setup_control
(
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    input  wire logic [7:0]  reg_ptr,
    input  wire logic        reg_wr_en,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_rd_en,
    output logic      [7:0]  reg_rdata,
    output logic             reg_rvalid,
    input  wire logic        constant_threshold_select,
    input  wire logic        conv_done,
    input  wire logic        conv_channel,
    input  wire logic [11:0] conv_data,
    input  wire logic        timeout_elapsed_ch1,
    input  wire logic        timeout_elapsed_ch2,
    output logic      [1:0]  ch1_range_select,
    output logic      [12:0] ch1_input_span_ff,
    output logic      [3:0]  ch1_offset_adjust_step,
    output logic             ch1_hysteresis_en,
    output logic      [4:0]  ch1_settling_exp,
    output logic      [15:0] ch1_average,
    output logic      [1:0]  ch2_range_select,
    output logic      [12:0] ch2_input_span_ff,
    output logic      [3:0]  ch2_offset_adjust_step,
    output logic             ch2_hysteresis_en,
    output logic      [4:0]  ch2_settling_exp,
    output logic      [15:0] ch2_average
);

    // span in femtofarads for a range code
    function automatic logic [12:0] span_of(input logic [1:0] code);
        case (code)
            2'b00:   span_of = csc_pkg::SPAN_CODE00_FF; // see RL2
            2'b01:   span_of = csc_pkg::SPAN_CODE01_FF;
            2'b10:   span_of = csc_pkg::SPAN_CODE10_FF;
            default: span_of = csc_pkg::SPAN_CODE11_FF;
        endcase
    endfunction

    // offset dac step for a range code
    function automatic logic [3:0] step_of(input logic [1:0] code);
        case (code)
            2'b00:   step_of = csc_pkg::STEP_CODE00; // see RL3
            2'b01:   step_of = csc_pkg::STEP_CODE01;
            2'b10:   step_of = csc_pkg::STEP_CODE10;
            default: step_of = csc_pkg::STEP_CODE11;
        endcase
    endfunction

    // log2 of the time constant from a setup byte
    function automatic logic [4:0] exp_of(input logic [7:0] setup);
        exp_of = {1'b0, setup[csc_pkg::SETTLE_MSB:csc_pkg::SETTLE_LSB]}
                 + csc_pkg::SETTLE_EXP_OFFS; // see RL10 see RL7
    endfunction

    // hysteresis on only in adaptive mode with the disable bit clear
    function automatic logic hyst_of(input logic [7:0] setup, input logic fixed);
        hyst_of = !fixed && !setup[csc_pkg::HYST_OFF_BIT]; // see RL4 see RL5 see RL8
    endfunction

    // one exponential averaging step, or a direct reload on timeout
    function automatic logic [27:0] avg_step(input logic [27:0] acc,
                                             input logic [11:0] data,
                                             input logic [4:0]  shamt,
                                             input logic        reload);
        logic signed [28:0] diff;
        logic signed [28:0] delta;
        diff  = $signed({1'b0, data, 16'h0000}) - $signed({1'b0, acc});
        delta = diff >>> shamt; // see RL6
        if (reload)
            avg_step = {data, 16'h0000}; // see RL9
        else
            avg_step = acc + delta[27:0];
    endfunction

    logic [7:0]  setup_r     [2];
    logic [7:0]  setup_nxt   [2];
    logic [27:0] acc_r       [2];
    logic [27:0] acc_nxt     [2];
    logic [7:0]  rdata_r;
    logic [7:0]  rdata_nxt;
    logic        rvalid_r;
    logic        rvalid_nxt;
    logic [1:0]  range_r     [2];
    logic [12:0] span_r      [2];
    logic [3:0]  step_r      [2];
    logic        hyst_r      [2];
    logic [4:0]  exp_r       [2];
    logic [1:0]  range_nxt   [2];
    logic [12:0] span_nxt    [2];
    logic [3:0]  step_nxt    [2];
    logic        hyst_nxt    [2];
    logic [4:0]  exp_nxt     [2];
    logic        timeout     [2];

    assign timeout[0] = timeout_elapsed_ch1;
    assign timeout[1] = timeout_elapsed_ch2;

    // register writes and pointer-addressed reads
    always_comb
    begin
        setup_nxt[0] = setup_r[0];
        setup_nxt[1] = setup_r[1];
        rdata_nxt    = rdata_r;
        rvalid_nxt   = reg_rd_en;
        if (reg_wr_en && reg_ptr == csc_pkg::CH1_SETUP_PTR)
            setup_nxt[0] = reg_wdata; // see RL1
        if (reg_wr_en && reg_ptr == csc_pkg::CH2_SETUP_PTR)
            setup_nxt[1] = reg_wdata; // see RL1
        if (reg_rd_en)
        begin
            if (reg_ptr == csc_pkg::CH1_SETUP_PTR)
                rdata_nxt = setup_r[0];
            else if (reg_ptr == csc_pkg::CH2_SETUP_PTR)
                rdata_nxt = setup_r[1];
            else
                rdata_nxt = 8'h00;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            setup_r[0] <= csc_pkg::SETUP_RESET; // see RL1
            setup_r[1] <= csc_pkg::SETUP_RESET;
            rdata_r    <= 8'h00;
            rvalid_r   <= 1'b0;
        end
        else
        begin
            setup_r[0] <= setup_nxt[0];
            setup_r[1] <= setup_nxt[1];
            rdata_r    <= rdata_nxt;
            rvalid_r   <= rvalid_nxt;
        end
    end

    // decoded per-channel controls and average update
    always_comb
    begin
        for (int i = 0; i < 2; i++)
        begin
            range_nxt[i] = setup_r[i][csc_pkg::RANGE_MSB:csc_pkg::RANGE_LSB];
            span_nxt[i]  = span_of(range_nxt[i]);
            step_nxt[i]  = step_of(range_nxt[i]);
            hyst_nxt[i]  = hyst_of(setup_r[i], constant_threshold_select);
            exp_nxt[i]   = exp_of(setup_r[i]);
            acc_nxt[i]   = acc_r[i];
            if (conv_done && (conv_channel == i[0]))
                acc_nxt[i] = avg_step(acc_r[i], conv_data, exp_nxt[i], timeout[i]);
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < 2; i++)
            begin
                range_r[i] <= 2'h0;
                span_r[i]  <= 13'h0000;
                step_r[i]  <= 4'h0;
                hyst_r[i]  <= 1'b0;
                exp_r[i]   <= 5'h00;
                acc_r[i]   <= 28'h0000000;
            end
        end
        else
        begin
            for (int i = 0; i < 2; i++)
            begin
                range_r[i] <= range_nxt[i];
                span_r[i]  <= span_nxt[i];
                step_r[i]  <= step_nxt[i];
                hyst_r[i]  <= hyst_nxt[i];
                exp_r[i]   <= exp_nxt[i];
                acc_r[i]   <= acc_nxt[i];
            end
        end
    end

    // outputs straight from flip-flops
    assign reg_rdata              = rdata_r;
    assign reg_rvalid             = rvalid_r;
    assign ch1_range_select       = range_r[0];
    assign ch1_input_span_ff      = span_r[0];
    assign ch1_offset_adjust_step = step_r[0];
    assign ch1_hysteresis_en      = hyst_r[0];
    assign ch1_settling_exp       = exp_r[0];
    assign ch1_average            = {acc_r[0][27:16], 4'h0};
    assign ch2_range_select       = range_r[1];
    assign ch2_input_span_ff      = span_r[1];
    assign ch2_offset_adjust_step = step_r[1];
    assign ch2_hysteresis_en      = hyst_r[1];
    assign ch2_settling_exp       = exp_r[1];
    assign ch2_average            = {acc_r[1][27:16], 4'h0};

endmodule

// ==== include/csc_pkg.sv ====
// constants for the two-channel converter setup control block
// assumes a serial front end that hands over pointer, strobes and byte data
// Notes on behaviour
// RL1 - Each channel has one 8-bit read/write setup register, channel one at pointer 0x0b and channel two at 0x0e, both resetting to 0x0b.
// RL2 - Bits 7:6 pick the input span: 00 is 2 pF, 01 is 0.5 pF, 10 is 1 pF and 11 is 4 pF.
// RL3 - The same bits pick the automatic offset adjust step: 4, 1, 2 or 8 offset DAC LSBs for codes 00, 01, 10 and 11.
// RL4 - In adaptive threshold mode bit 4 set to 1 turns hysteresis off and set to 0 leaves it on.
// RL5 - In constant threshold mode hysteresis is always off and bit 4 changes nothing.
// RL6 - After an input step the average moves toward the new value exponentially, by the step times (1 - e^(-N/time constant)) after N conversions.
// RL7 - Bits 3:0 program the average settling time constant from 2 up to 65,536 conversions.
// RL8 - A configuration bit at 1 selects constant thresholds and at 0 adaptive thresholds built from past data.
// RL9 - When an enabled adaptive timeout elapses the average is loaded with the latest result, dropping its history.
// RL10 - The time constant is two to the power of the settling field plus one, so 0 to 15 give 2 to 65,536.
package csc_pkg;
    localparam logic [7:0] CH1_SETUP_PTR   = 8'h0b;
    localparam logic [7:0] CH2_SETUP_PTR   = 8'h0e;
    localparam logic [7:0] SETUP_RESET     = 8'h0b;
    localparam int         RANGE_MSB       = 7;
    localparam int         RANGE_LSB       = 6;
    localparam int         HYST_OFF_BIT    = 4;
    localparam int         SETTLE_MSB      = 3;
    localparam int         SETTLE_LSB      = 0;
    localparam int         DATA_W          = 12;
    localparam int         FRAC_W          = 16;
    localparam int         ACC_W           = DATA_W + FRAC_W;
    localparam logic [4:0] SETTLE_EXP_OFFS = 5'h01;
    // input spans in femtofarads
    localparam logic [12:0] SPAN_CODE00_FF = 13'h07d0;
    localparam logic [12:0] SPAN_CODE01_FF = 13'h01f4;
    localparam logic [12:0] SPAN_CODE10_FF = 13'h03e8;
    localparam logic [12:0] SPAN_CODE11_FF = 13'h0fa0;
    // offset dac step sizes in lsbs
    localparam logic [3:0] STEP_CODE00 = 4'h4;
    localparam logic [3:0] STEP_CODE01 = 4'h1;
    localparam logic [3:0] STEP_CODE10 = 4'h2;
    localparam logic [3:0] STEP_CODE11 = 4'h8;
endpackage

// ==== test/csc_setup_properties.sv ====
// port checker for the setup control block
// assumes one clock and a synchronous active low reset
`timescale 1ns/10ps
module csc_setup_props
(
    input wire logic        sys_clk,
    input wire logic        rst_n,
    input wire logic [7:0]  reg_ptr,
    input wire logic        reg_wr_en,
    input wire logic [7:0]  reg_wdata,
    input wire logic        reg_rd_en,
    input wire logic        reg_rvalid,
    input wire logic        constant_threshold_select,
    input wire logic        conv_done,
    input wire logic        conv_channel,
    input wire logic [11:0] conv_data,
    input wire logic        timeout_elapsed_ch1,
    input wire logic [1:0]  ch1_range_select,
    input wire logic [3:0]  ch1_offset_adjust_step,
    input wire logic        ch1_hysteresis_en,
    input wire logic [15:0] ch1_average
);
    // reset disables every check
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // read answer and write decode
    rv_follow_a: assert property (reg_rd_en |=> reg_rvalid) else $error("rvalid late");
    rv_pulse_a: assert property (!reg_rd_en |=> !reg_rvalid) else $error("stray rvalid");
    range_write_a: assert property (reg_wr_en && reg_ptr == 8'h0b |=> ##1
        ch1_range_select == $past(reg_wdata[7:6], 2)) else $error("range not taken");
    step_map_a: assert property ($past(rst_n) |-> ch1_offset_adjust_step ==
        {ch1_range_select == 2'h3, ch1_range_select == 2'h0, ch1_range_select == 2'h2,
        ch1_range_select == 2'h1}) else $error("step mismatch");
    // hysteresis against mode and setup bit
    hyst_fixed_a: assert property (constant_threshold_select |=> !ch1_hysteresis_en)
        else $error("hysteresis in fixed mode");
    hyst_adapt_a: assert property (reg_wr_en && reg_ptr == 8'h0b && !reg_wdata[4] ##1
        !constant_threshold_select |=> ch1_hysteresis_en) else $error("hysteresis missing");
    // average moves only on its own conversions
    avg_reload_a: assert property (conv_done && !conv_channel && timeout_elapsed_ch1
        |=> ch1_average == {$past(conv_data), 4'h0}) else $error("reload missed");
    avg_hold_a: assert property (!(conv_done && !conv_channel) |=> $stable(ch1_average))
        else $error("average drifted");
endmodule
bind csc_setup_control csc_setup_props chk_u (.sys_clk(sys_clk), .rst_n(rst_n),
    .reg_ptr(reg_ptr), .reg_wr_en(reg_wr_en), .reg_wdata(reg_wdata), .reg_rd_en(reg_rd_en),
    .reg_rvalid(reg_rvalid), .constant_threshold_select(constant_threshold_select),
    .conv_done(conv_done), .conv_channel(conv_channel), .conv_data(conv_data),
    .timeout_elapsed_ch1(timeout_elapsed_ch1), .ch1_range_select(ch1_range_select),
    .ch1_offset_adjust_step(ch1_offset_adjust_step), .ch1_hysteresis_en(ch1_hysteresis_en),
    .ch1_average(ch1_average));

// ==== test/csc_host_model.sv ====
// host model: register pointer, strobes and write byte
// assumes calls start right after a falling edge
`timescale 1ns/10ps
module csc_host_model
(
    input  wire logic       sys_clk,
    input  wire logic [7:0] reg_rdata,
    input  wire logic       reg_rvalid,
    output logic      [7:0] reg_ptr = 8'h00,
    output logic            reg_wr_en = 1'b0,
    output logic      [7:0] reg_wdata = 8'hff,
    output logic            reg_rd_en = 1'b0
);
    // one write strobe, data scrambled once released
    task automatic wr(input logic [7:0] p, input logic [7:0] x);
        @(negedge sys_clk);
        reg_ptr = p;
        reg_wdata = x;
        reg_wr_en = 1'b1;
        @(negedge sys_clk);
        reg_wr_en = 1'b0;
        reg_wdata = ~x;
    endtask
    // one read strobe, bounded wait for rvalid
    task automatic rd(input logic [7:0] p, output logic [7:0] x, output logic ok);
        @(negedge sys_clk);
        reg_ptr = p;
        reg_rd_en = 1'b1;
        @(negedge sys_clk);
        reg_rd_en = 1'b0;
        for (int i = 0; i < 4 && reg_rvalid !== 1'b1; i++) @(negedge sys_clk);
        ok = reg_rvalid;
        x = reg_rdata;
    endtask
endmodule

// ==== test/cap_converter_setup_control_tb.sv ====
// bench: reset decode, then setup rows, refusal, average and reset cases
// assumes the host model makes every register access
`timescale 1ns/10ps
module cap_converter_setup_control_tb;
    typedef struct packed {logic [7:0] w; logic c; logic [12:0] s; logic [3:0] p; logic h;
        logic [4:0] e;} csc_row_t;
    csc_row_t rows [4] = '{'{8'h00, 1'b0, 13'h07d0, 4'h4, 1'b1, 5'h01},
        '{8'h5f, 1'b0, 13'h01f4, 4'h1, 1'b0, 5'h10}, '{8'h87, 1'b1, 13'h03e8, 4'h2, 1'b0, 5'h08},
        '{8'hc4, 1'b0, 13'h0fa0, 4'h8, 1'b1, 5'h05}};
    logic sys_clk = 1'b0, rst_n = 1'b0, ct = 1'b0, cd = 1'b0, cc = 1'b0, t1 = 1'b0, t2 = 1'b0;
    logic [11:0] dat = 12'h000;
    logic [7:0] ptr, wd, rdat, v;
    logic we, re, rv, ok, h1, h2;
    logic [1:0] r1, r2;
    logic [12:0] s1, s2;
    logic [3:0] p1, p2;
    logic [4:0] e1, e2;
    logic [15:0] a1, a2;
    int mismatches = 0;
    int checked = 0;
    csc_host_model host_u (.sys_clk(sys_clk), .reg_rdata(rdat), .reg_rvalid(rv), .reg_ptr(ptr),
        .reg_wr_en(we), .reg_wdata(wd), .reg_rd_en(re));
    csc_setup_control dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .reg_ptr(ptr), .reg_wr_en(we),
        .reg_wdata(wd), .reg_rd_en(re), .reg_rdata(rdat), .reg_rvalid(rv),
        .constant_threshold_select(ct), .conv_done(cd), .conv_channel(cc), .conv_data(dat),
        .timeout_elapsed_ch1(t1), .timeout_elapsed_ch2(t2), .ch1_range_select(r1),
        .ch1_input_span_ff(s1), .ch1_offset_adjust_step(p1), .ch1_hysteresis_en(h1),
        .ch1_settling_exp(e1), .ch1_average(a1), .ch2_range_select(r2),
        .ch2_input_span_ff(s2), .ch2_offset_adjust_step(p2), .ch2_hysteresis_en(h2),
        .ch2_settling_exp(e2), .ch2_average(a2));
    // compare, read-compare, conversion and verdict helpers
    task automatic chk(input logic [31:0] g, input logic [31:0] x, input string m);
        checked++;
        if (g !== x)
        begin
            mismatches++;
            $display("BAD %0t %s got %h want %h", $time, m, g, x);
        end
    endtask
    task automatic rdc(input logic [7:0] p, input logic [7:0] x);
        host_u.rd(p, v, ok);
        if (ok !== 1'b1)
        begin
            mismatches++;
            $display("BAD %0t read answer timed out", $time);
            conclude();
        end
        else
            chk({24'h0, v}, {24'h0, x}, "readback");
    endtask
    task automatic conv(input logic c, input logic [11:0] x, input logic t);
        @(negedge sys_clk);
        {cc, dat, t1, t2, cd} = {c, x, t & !c, t & c, 1'b1};
        @(negedge sys_clk);
        {cd, t1, t2} = 3'h0;
    endtask
    task automatic conclude();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // free running clock
    initial
    begin
        forever #5 sys_clk = ~sys_clk;
    end
    // main sequence
    initial
    begin
        repeat (20) @(negedge sys_clk);
        rst_n = 1'b1;
        rdc(8'h0e, 8'h0b);
        chk({r1, s1, p1, h1, e1}, {2'h0, 13'h07d0, 4'h4, 1'b1, 5'h0c}, "reset decode");
        $display("reset test done");
        foreach (rows[i])
        begin
            ct = rows[i].c;
            host_u.wr(8'h0b, rows[i].w);
            host_u.wr(8'h0e, rows[i].w);
            @(negedge sys_clk);
            chk({r1, s1, p1, h1, e1}, {rows[i].w[7:6], rows[i][22:0]}, "ch1 decode");
            chk({r2, s2, p2, h2, e2}, {rows[i].w[7:6], rows[i][22:0]}, "ch2 decode");
            rdc(8'h0b, rows[i].w);
        end
        $display("row tests done");
        host_u.wr(8'h0c, 8'hff);
        rdc(8'h0c, 8'h00);
        rdc(8'h0e, 8'hc4);
        host_u.wr(8'h0b, 8'h00);
        conv(1'b0, 12'h800, 1'b0);
        chk({16'h0, a1}, 32'h4000, "avg half");
        conv(1'b0, 12'h800, 1'b0);
        chk({16'h0, a1}, 32'h6000, "avg step");
        conv(1'b1, 12'hfff, 1'b1);
        chk({a2, a1}, 32'hfff06000, "ch2 reload");
        conv(1'b0, 12'h123, 1'b1);
        chk({16'h0, a1}, 32'h1230, "ch1 reload");
        rst_n = 1'b0;
        repeat (2) @(negedge sys_clk);
        rst_n = 1'b1;
        rdc(8'h0b, 8'h0b);
        $display("edge tests done");
        conclude();
    end
endmodule
